// >>> shared/pmcfg_pkg.sv
// ----------------------------------------------------------------
// Mode configuration register constants
// ----------------------------------------------------------------
package pmcfg_pkg;
   // Register offsets on the serial port
   localparam logic [7:0] MODE2_PART3_ADDR  = 8'h2d;
   localparam logic [7:0] MODE3_PART0_ADDR  = 8'h2e;
   // Reset values
   localparam logic [7:0] MODE2_PART3_RST   = 8'h0c;
   localparam logic [7:0] MODE3_PART0_RST   = 8'h1c;
   // Field positions
   localparam int SHIP_EN_BIT      = 7;
   localparam int SRC_PIN_BIT      = 6;
   localparam int LDO_OFFSET_BIT   = 5;
   // Active mode code to which the mode-3 fields belong
   localparam logic [1:0] MODE_THREE = 2'h3;
   // Core buck decode, millivolts
   localparam logic [5:0]  CORE_LIN_MAX  = 6'h28;
   localparam logic [5:0]  CORE_FIXED    = 6'h3f;
   localparam logic [11:0] CORE_BASE_MV  = 12'h1f4;
   localparam logic [11:0] CORE_SAT_MV   = 12'h5dc;
   localparam logic [11:0] CORE_FIX_MV   = 12'h708;
   // System LDO decode, millivolts
   localparam logic [4:0]  LDO_LIN_MAX   = 5'h18;
   localparam logic [11:0] LDO_BASE_MV   = 12'h5dc;
   localparam logic [11:0] LDO_SAT_MV    = 12'h834;
   localparam logic [11:0] LDO_OFFS_MV   = 12'h4b0;
   localparam logic [11:0] STEP_MV       = 12'h019;
   // Serial slave address; value is arbitrary
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h61;
endpackage

// >>> logic/pmcfg_regs.sv
`timescale 1ns/1ps
// What this block does
// - Bit 7 sets ship mode in mode 3
// - Source bit 0: register mode bits only, while in mode 3
// - Source bit 1: external mode pins only, while in mode 3
// - Core buck code: 25mV steps, saturate, 1.8V
// - LDO code resets 01100, saturates 2.1V
// - Mode-3 register fully readable and writable
// - LDO offset bit adds 1.2V
module pmcfg_regs #(
   parameter logic [6:0] DEV_ADDR = pmcfg_pkg::DEV_ADDR_DEFAULT
) (
   // Clock and reset
   input  wire  logic        clock_in,
   input  wire  logic        sys_rst_in,
   // Serial bus pins, open drain data
   input  wire  logic        scl_in,
   input  wire  logic        sda_in,
   output logic              sda_out_out,
   output logic              sda_oe_out,
   // Mode selection sources
   input  wire  logic        mode_select_pin0_in,
   input  wire  logic        mode_select_pin1_in,
   input  wire  logic        mode_reg_bit0_in,
   input  wire  logic        mode_reg_bit1_in,
   input  wire  logic        mode_src_other_in,
   // Regulator settings
   output logic [1:0]        active_mode_out,
   output logic              ship_mode_out,
   output logic              core_buck_apply_out,
   output logic [11:0]       core_buck_mv_out,
   output logic [11:0]       sys_ldo_mv_out
);
   import pmcfg_pkg::*;

   // ----------------------------------------------------------------
   // Decode functions
   // ----------------------------------------------------------------
   // Core buck code to millivolts
   function automatic logic [11:0] core_mv(input logic [5:0] code);
      logic [11:0] lin;
      lin = CORE_BASE_MV + 12'(code) * STEP_MV;
      if (code == CORE_FIXED) begin
         core_mv = CORE_FIX_MV;
      end else if (code > CORE_LIN_MAX) begin
         core_mv = CORE_SAT_MV;
      end else begin
         core_mv = lin;
      end
   endfunction

   // System LDO code plus offset to millivolts
   function automatic logic [11:0] ldo_mv(input logic [4:0] code, input logic offs);
      logic [11:0] base;
      base = (code > LDO_LIN_MAX) ? LDO_SAT_MV : LDO_BASE_MV + 12'(code) * STEP_MV;
      ldo_mv = offs ? base + LDO_OFFS_MV : base;
   endfunction

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [3:0] meta_q;     // First stage, read only by second
   logic [3:0] sync_q;     // scl, sda, pin0, pin1
   logic       scl_p_q;    // Delayed scl for edges
   logic       sda_p_q;    // Delayed sda for edges

   // Two flops on every pin, then one more on scl and sda for edge detection
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         meta_q  <= 4'hf;
         sync_q  <= 4'hf;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         meta_q  <= {scl_in, sda_in, mode_select_pin0_in, mode_select_pin1_in};
         sync_q  <= meta_q;
         scl_p_q <= sync_q[3];
         sda_p_q <= sync_q[2];
      end
   end

   wire scl_s    = sync_q[3];
   wire sda_s    = sync_q[2];
   wire scl_rise = scl_s & ~scl_p_q;
   wire scl_fall = ~scl_s & scl_p_q;
   wire bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
   wire bus_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   logic [7:0] mode2_part3_q;   // Watchdog, LDO offset, LDO code
   logic [7:0] mode3_part0_q;   // Ship, source select, core buck code

   // ----------------------------------------------------------------
   // Serial slave
   // ----------------------------------------------------------------
   typedef enum logic [6:0] {
      ST_IDLE  = 7'b0000001,
      ST_ADDR  = 7'b0000010,
      ST_AACK  = 7'b0000100,
      ST_WRITE = 7'b0001000,
      ST_WACK  = 7'b0010000,
      ST_READ  = 7'b0100000,
      ST_RACK  = 7'b1000000
   } pmcfg_state_t;

   pmcfg_state_t state_q;
   logic [7:0]   shift_q;     // Byte being shifted
   logic [3:0]   cnt_q;       // Bits done in this byte
   logic [7:0]   ptr_q;       // Register pointer, auto increments
   logic         ptr_ph_q;    // Next written byte is the pointer
   logic         rw_q;        // Read transfer
   logic         nack_q;      // Master refused the last byte
   logic         sda_oe_q;    // Pull data low
   logic         sda_out_q;   // Level driven while enabled

   // Read mux; unmapped offsets read as zero
   wire [7:0] rdata = (ptr_q == MODE2_PART3_ADDR) ? mode2_part3_q :
                      (ptr_q == MODE3_PART0_ADDR) ? mode3_part0_q : 8'h00;
   wire byte_done = scl_fall & (cnt_q == 4'h8);
   wire data_wr   = (state_q == ST_WRITE) & byte_done & ~ptr_ph_q;

   // Bus state machine; start and stop take priority everywhere
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         state_q   <= ST_IDLE;
         shift_q   <= 8'h00;
         cnt_q     <= 4'h0;
         ptr_q     <= 8'h00;
         ptr_ph_q  <= 1'b0;
         rw_q      <= 1'b0;
         nack_q    <= 1'b0;
         sda_oe_q  <= 1'b0;
         sda_out_q <= 1'b0;
      end else if (bus_start) begin
         state_q  <= ST_ADDR;
         cnt_q    <= 4'h0;
         sda_oe_q <= 1'b0;
      end else if (bus_stop) begin
         state_q  <= ST_IDLE;
         sda_oe_q <= 1'b0;
      end else begin
         case (state_q)
            ST_ADDR, ST_WRITE: begin
               // Shift on rising clock, act after eighth bit
               if (scl_rise && cnt_q != 4'h8) begin
                  shift_q <= {shift_q[6:0], sda_s};
                  cnt_q   <= cnt_q + 4'h1;
               end else if (byte_done && state_q == ST_ADDR) begin
                  // Only our address is acknowledged
                  if (shift_q[7:1] == DEV_ADDR) begin
                     state_q  <= ST_AACK;
                     rw_q     <= shift_q[0];
                     sda_oe_q <= 1'b1;
                  end else begin
                     state_q <= ST_IDLE;
                  end
               end else if (byte_done) begin
                  // Pointer byte first, then data with increment
                  if (ptr_ph_q) begin
                     ptr_q <= shift_q;
                  end else begin
                     ptr_q <= ptr_q + 8'h01;
                  end
                  ptr_ph_q <= 1'b0;
                  state_q  <= ST_WACK;
                  sda_oe_q <= 1'b1;
               end
            end
            ST_AACK: begin
               if (scl_fall) begin
                  cnt_q <= 4'h0;
                  if (rw_q) begin
                     state_q  <= ST_READ;
                     shift_q  <= rdata;
                     sda_oe_q <= ~rdata[7];
                  end else begin
                     state_q  <= ST_WRITE;
                     ptr_ph_q <= 1'b1;
                     sda_oe_q <= 1'b0;
                  end
               end
            end
            ST_WACK: begin
               if (scl_fall) begin
                  state_q  <= ST_WRITE;
                  cnt_q    <= 4'h0;
                  sda_oe_q <= 1'b0;
               end
            end
            ST_READ: begin
               // Drive next bit on each falling clock
               if (scl_fall) begin
                  cnt_q <= cnt_q + 4'h1;
                  if (cnt_q == 4'h7) begin
                     state_q  <= ST_RACK;
                     sda_oe_q <= 1'b0;
                     ptr_q    <= ptr_q + 8'h01;
                  end else begin
                     shift_q  <= {shift_q[6:0], 1'b0};
                     sda_oe_q <= ~shift_q[6];
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  nack_q <= sda_s;
               end else if (scl_fall) begin
                  // A refused byte ends the read burst
                  if (nack_q) begin
                     state_q <= ST_IDLE;
                  end else begin
                     state_q  <= ST_READ;
                     cnt_q    <= 4'h0;
                     shift_q  <= rdata;
                     sda_oe_q <= ~rdata[7];
                  end
               end
            end
            default: begin
               state_q  <= ST_IDLE;
               sda_oe_q <= 1'b0;
            end
         endcase
      end
   end

   // Register writes; writes to other offsets are acknowledged and dropped
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         mode2_part3_q <= MODE2_PART3_RST;
         mode3_part0_q <= MODE3_PART0_RST;
      end else if (data_wr && ptr_q == MODE2_PART3_ADDR) begin
         mode2_part3_q <= shift_q;
      end else if (data_wr && ptr_q == MODE3_PART0_ADDR) begin
         mode3_part0_q <= shift_q;
      end
   end

   // ----------------------------------------------------------------
   // Mode selection and regulator settings
   // ----------------------------------------------------------------
   logic [1:0] mode_q;
   wire in_mode3  = (mode_q == MODE_THREE);
   // Mode-3 source bit counts only while mode 3 is active
   wire use_pins  = in_mode3 ? mode3_part0_q[SRC_PIN_BIT] : mode_src_other_in;
   wire [1:0] mode_d = use_pins ? {sync_q[0], sync_q[1]}
                                : {mode_reg_bit1_in, mode_reg_bit0_in};

   // Settings registered so every output comes from a flop
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         mode_q        <= 2'h0;
         ship_mode_out <= 1'b0;
         core_buck_apply_out <= 1'b0;
         core_buck_mv_out    <= CORE_BASE_MV;
         sys_ldo_mv_out      <= LDO_BASE_MV;
      end else begin
         mode_q        <= mode_d;
         ship_mode_out <= in_mode3 & mode3_part0_q[SHIP_EN_BIT];
         core_buck_apply_out <= in_mode3;
         core_buck_mv_out    <= core_mv(mode3_part0_q[5:0]);
         sys_ldo_mv_out      <= ldo_mv(mode2_part3_q[4:0],
                                       mode2_part3_q[LDO_OFFSET_BIT]);
      end
   end

   assign active_mode_out = mode_q;
   assign sda_oe_out      = sda_oe_q;
   assign sda_out_out     = sda_out_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);

   property p_ship;
      ##1 ship_mode_out == ($past(in_mode3) && $past(mode3_part0_q[7]));
   endproperty
   a_ship: assert property (p_ship) else $error("ship mode mismatch");
   property p_src_reg;
      in_mode3 && !mode3_part0_q[6] |=> mode_q == $past({mode_reg_bit1_in, mode_reg_bit0_in});
   endproperty
   a_src_reg: assert property (p_src_reg) else $error("register source ignored");
   property p_src_pin;
      in_mode3 && mode3_part0_q[6] |=> mode_q == $past({sync_q[0], sync_q[1]});
   endproperty
   a_src_pin: assert property (p_src_pin) else $error("pin source ignored");
   property p_core;
      mode3_part0_q[5:0] == 6'h3f |=> core_buck_mv_out == 12'h708;
   endproperty
   a_core: assert property (p_core) else $error("fixed core code wrong");
   property p_core_sat;
      mode3_part0_q[5:0] > 6'h28 && mode3_part0_q[5:0] != 6'h3f |=> core_buck_mv_out == 12'h5dc;
   endproperty
   a_core_sat: assert property (p_core_sat) else $error("core saturation wrong");
   property p_ldo;
      mode2_part3_q[5:0] == 6'h1f |=> sys_ldo_mv_out == 12'h834;
   endproperty
   a_ldo: assert property (p_ldo) else $error("ldo saturation wrong");
   property p_offs;
      mode2_part3_q[5:0] == 6'h20 |=> sys_ldo_mv_out == 12'ha8c;
   endproperty
   a_offs: assert property (p_offs) else $error("ldo offset wrong");
   // Written mode-3 byte must be the one stored, on the next clock
   property p_wr;
      data_wr && ptr_q == MODE3_PART0_ADDR |=> mode3_part0_q == $past(shift_q);
   endproperty
   a_wr: assert property (p_wr) else $error("mode-3 write lost");
   property p_apply;
      !in_mode3 |=> !ship_mode_out && !core_buck_apply_out;
   endproperty
   a_apply: assert property (p_apply) else $error("mode-3 applied outside mode 3");

   c_write: cover property (data_wr && ptr_q == 8'h2e);
   c_read:  cover property (state_q == ST_RACK && ptr_q == 8'h2f);
   c_ship:  cover property (ship_mode_out);
   c_pins:  cover property (in_mode3 && mode3_part0_q[6]);
endmodule

// >>> verification/pmcfg_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------
// Serial bus master standing in for the host
// ------------------------------------------------
module pmcfg_host_model #(
   parameter int HALF = 20                   // Clocks per half serial period
) (
   // Clock and wired data level
   input  wire logic clock_in,
   input  wire logic sda_bus_in,
   // Open drain outputs
   output logic      scl_out,
   output logic      sda_low_out
);
   // Bus idles released, clock high
   initial begin
      scl_out     = 1'b1;
      sda_low_out = 1'b0;
   end
   // Half period wait
   task automatic pause;
      repeat (HALF) @(posedge clock_in);
   endtask
   // Start, also usable as repeated start
   task automatic start_cond;
      sda_low_out <= 1'b0;
      pause();
      scl_out <= 1'b1;
      pause();
      sda_low_out <= 1'b1;
      pause();
      scl_out <= 1'b0;
      pause();
   endtask
   // Stop: data rises while clock high
   task automatic stop_cond;
      sda_low_out <= 1'b1;
      pause();
      scl_out <= 1'b1;
      pause();
      sda_low_out <= 1'b0;
      pause();
   endtask
   // One bit; data moves two clocks after the fall so it never races the clock
   task automatic bit_cycle(input logic b, output logic s);
      repeat (2) @(posedge clock_in);
      sda_low_out <= ~b;
      pause();
      scl_out <= 1'b1;
      pause();
      s = sda_bus_in;
      scl_out <= 1'b0;
   endtask
   // Byte out, returns acknowledge
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(b[i], s);
      end
      bit_cycle(1'b1, s);
      ack = ~s;
   endtask
   // Byte in; last high sends a not-acknowledge
   task automatic rbyte(output logic [7:0] b, input logic last);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(1'b1, s);
         b[i] = s;
      end
      bit_cycle(last, s);
   endtask
endmodule

// >>> verification/pmcfg_regs_tb_top.sv
`timescale 1ns/1ps
module pmcfg_regs_tb_top;
   import pmcfg_pkg::*;
   // ------------------------------------------------
   // Stimulus and observed signals
   // ------------------------------------------------
   logic        clock_in   = 1'b0;
   logic        sys_rst_in = 1'b1;
   logic [1:0]  pins       = 2'h0;      // External mode pins
   logic [1:0]  regb       = 2'h0;      // Internal mode bits
   logic        src_other  = 1'b0;      // Source select outside mode 3
   wire         scl, sda_low, sda_o, sda_oe, ship, apply;
   wire  [1:0]  mode;
   wire  [11:0] core_mv, ldo_mv;
   wire         sda_bus = ~(sda_low | sda_oe);  // Pull-up wins unless pulled
   int          errors = 0;
   int          samples_checked = 0;
   // Core codes at the edges of each decode band
   logic [5:0]  codes [6] = '{6'h00, 6'h01, 6'h28, 6'h29, 6'h3e, 6'h3f};
   logic [7:0]  ldo_w [7] = '{8'h00, 8'h18, 8'h19, 8'h1f, 8'h20, 8'h2c, 8'h3f};
   logic [11:0] ldo_e [7] = '{12'h5dc, 12'h834, 12'h834, 12'h834, 12'ha8c, 12'hbb8, 12'hce4};
   always #12.5 clock_in = ~clock_in;
   // ------------------------------------------------
   // Design and host
   // ------------------------------------------------
   pmcfg_regs dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .scl_in(scl),
      .sda_in(sda_bus), .sda_out_out(sda_o), .sda_oe_out(sda_oe),
      .mode_select_pin0_in(pins[0]), .mode_select_pin1_in(pins[1]),
      .mode_reg_bit0_in(regb[0]), .mode_reg_bit1_in(regb[1]),
      .mode_src_other_in(src_other), .active_mode_out(mode), .ship_mode_out(ship),
      .core_buck_apply_out(apply), .core_buck_mv_out(core_mv), .sys_ldo_mv_out(ldo_mv));
   pmcfg_host_model host (.clock_in(clock_in), .sda_bus_in(sda_bus), .scl_out(scl),
      .sda_low_out(sda_low));
   // ------------------------------------------------
   // Tasks
   // ------------------------------------------------
   task automatic check(input logic [11:0] got, input logic [11:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic settle;
      repeat (8) @(posedge clock_in);
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      logic k;
      host.start_cond();
      host.wbyte({DEV_ADDR_DEFAULT, 1'b0}, k);
      check({11'h0, k}, 12'h1);
      host.wbyte(a, k);
      host.wbyte(d, k);
      host.stop_cond();
      settle();
   endtask
   task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
      logic k;
      logic [7:0] d;
      host.start_cond();
      host.wbyte({DEV_ADDR_DEFAULT, 1'b0}, k);
      host.wbyte(a, k);
      host.start_cond();
      host.wbyte({DEV_ADDR_DEFAULT, 1'b1}, k);
      host.rbyte(d, 1'b1);
      host.stop_cond();
      check({4'h0, d}, {4'h0, exp});
   endtask
   // Linear 25 mV steps, flat band, then the fixed top code
   function automatic logic [11:0] core_exp(input logic [5:0] c);
      if (c == 6'h3f) return 12'h708;
      if (c > 6'h28) return 12'h5dc;
      return 12'h1f4 + 12'h019 * {6'h0, c};
   endfunction
   task automatic close_out;
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Watchdog well beyond the expected run length
   initial begin
      repeat (90000) @(posedge clock_in);
      errors++;
      close_out();
   end
   // ------------------------------------------------
   // Main sequence
   // ------------------------------------------------
   initial begin
      logic k;
      logic [7:0] d2;
      repeat (16) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      settle();
      check(ldo_mv, 12'h708);
      check({11'h0, apply}, 12'h0);
      check({11'h0, sda_o}, 12'h0);
      reg_read(8'h2e, 8'h1c);
      reg_read(8'h2d, 8'h0c);
      regb <= 2'h3;
      settle();
      check({10'h0, mode}, 12'h3);
      check(core_mv, 12'h4b0);
      foreach (codes[i]) begin
         reg_write(8'h2e, {2'h0, codes[i]});
         check(core_mv, core_exp(codes[i]));
         reg_read(8'h2e, {2'h0, codes[i]});
      end
      reg_write(8'h2e, 8'h9c);
      check({11'h0, ship}, 12'h1);
      check({11'h0, apply}, 12'h1);
      pins <= 2'h1;
      settle();
      check({10'h0, mode}, 12'h3);
      regb <= 2'h0;
      settle();
      check({11'h0, ship}, 12'h0);
      check({11'h0, apply}, 12'h0);
      regb <= 2'h3;
      settle();
      reg_write(8'h2e, 8'h5c);
      src_other <= 1'b1;
      pins <= 2'h3;
      settle();
      regb <= 2'h1;
      settle();
      check({10'h0, mode}, 12'h3);
      check({11'h0, ship}, 12'h0);
      pins <= 2'h2;
      settle();
      settle();
      check({10'h0, mode}, 12'h2);
      foreach (ldo_w[i]) begin
         reg_write(8'h2d, ldo_w[i]);
         check(ldo_mv, ldo_e[i]);
      end
      reg_write(8'h40, 8'ha5);
      reg_read(8'h40, 8'h00);
      reg_read(8'h2d, 8'h3f);
      // Burst write then burst read, pointer auto increments
      host.start_cond();
      host.wbyte({DEV_ADDR_DEFAULT, 1'b0}, k);
      host.wbyte(8'h2d, k);
      host.wbyte(8'h01, k);
      host.wbyte(8'h1d, k);
      host.start_cond();
      host.wbyte({DEV_ADDR_DEFAULT, 1'b0}, k);
      host.wbyte(8'h2d, k);
      host.start_cond();
      host.wbyte({DEV_ADDR_DEFAULT, 1'b1}, k);
      host.rbyte(d2, 1'b0);
      check({4'h0, d2}, 12'h001);
      host.rbyte(d2, 1'b1);
      check({4'h0, d2}, 12'h01d);
      host.stop_cond();
      settle();
      host.start_cond();
      host.wbyte({~DEV_ADDR_DEFAULT, 1'b0}, k);
      check({11'h0, k}, 12'h0);
      host.stop_cond();
      close_out();
   end
endmodule
